/* logic/ubb_pkg.sv */
// Constants, types and mode codes for the bit-bang parallel port.
// Assumes one 200 MHz clock and a synchronous active-high reset.
// What this block does
// - Async mode brings internal read and write strobes out to pins.
// - Async mode puts each host byte onto output pins without handshake.
// - Each pin is individually an input or an output.
// - Async output bytes are paced by the baud generator tick.
// - Async outputs change only on new byte plus tick; else hold last value.
// - Mode command value 0x01 selects asynchronous bit-bang.
// - Sync outputs update only per received byte; write strobe then pulses.
// - Sync pin samples go to host only after a byte was written.
// - Sync mode processes a byte only while host queue has room.
// - Sync pins sampled before new output, so samples lag one byte.
// - Mode command value 0x04 selects synchronous bit-bang.
// - Sync cycle: sample, send, update outputs, one setup clock, write strobe.
// - Read strobe rising edge marks pin data captured and queued to host.
// - Mode command carries direction mask kept until next command.
// - Mode command value 0x00 leaves the special interface mode.
package ubb_pkg;
   localparam int          PIN_W          = 8;
   localparam logic [7:0]  MODE_CMD_RESET = 8'h00;
   localparam logic [7:0]  MODE_CMD_ASYNC = 8'h01;
   localparam logic [7:0]  MODE_CMD_SYNC  = 8'h04;
   localparam logic [7:0]  PIN_RESET_VAL  = 8'h00;
   localparam logic [3:0]  SETUP_CLOCKS   = 4'h1;

   typedef enum logic [1:0] {UBB_OFF, UBB_ASYNC, UBB_SYNC} ubb_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_SEND,
      ST_SETUP,
      ST_STROBE
   } ubb_state_e;

   typedef struct packed {
      logic [PIN_W-1:0] value;
      logic [PIN_W-1:0] mask;
   } ubb_cmd_s;

   typedef struct packed {
      logic [PIN_W-1:0] level;
      logic [PIN_W-1:0] drive;
   } ubb_pins_s;
endpackage

/* logic/ubb_sync.sv */
// Two-flop synchroniser for the pin inputs.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ubb_sync
#(
   parameter int W = 8
)
(
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] stage1;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         stage1 <= '0;
         q      <= '0;
      end
      else
      begin
         stage1 <= d;
         q      <= stage1;
      end
   end
endmodule // ubb_sync
`default_nettype wire

/* logic/ubb_port.sv */
// Bit-bang parallel port: host bytes to pins, pin samples back to host.
// Assumes valid/ready queues on sys_clk and baudTick from logic on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ubb_port
   import ubb_pkg::*;
(
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             modeCmdValid,
   input  wire ubb_cmd_s         modeCmd,
   input  wire logic             baudTick,
   input  wire logic             fromHostValid,
   input  wire logic [PIN_W-1:0] fromHostData,
   output var  logic             fromHostReady,
   output var  logic             toHostValid,
   output var  logic [PIN_W-1:0] toHostData,
   input  wire logic             toHostReady,
   input  wire logic [PIN_W-1:0] pinIn,
   output var  ubb_pins_s        pinDrive,
   output var  logic             pinReadStrobeN,
   output var  logic             pinWriteStrobeN,
   output var  ubb_mode_e        mode
);
   logic [PIN_W-1:0] pinSync;
   logic [PIN_W-1:0] holdByte;
   logic [PIN_W-1:0] pinLevel;
   logic [PIN_W-1:0] pinDir;
   logic             pending;
   logic [3:0]       setupCnt;
   ubb_state_e       state;
   logic             accept;
   logic             toHostFree;

   ubb_sync #(.W(PIN_W)) u_sync
   (
      .sys_clk (sys_clk),
      .srst    (srst),
      .d       (pinIn),
      .q       (pinSync)
   );

   assign accept     = fromHostValid && fromHostReady;
   assign toHostFree = !toHostValid || toHostReady;

   // Level and direction each have one writing process
   assign pinDrive = '{level: pinLevel, drive: pinDir};

   // Mode selection from the mode command
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         mode <= UBB_OFF;
      else if (modeCmdValid)
      begin
         case (modeCmd.value)
            MODE_CMD_ASYNC: mode <= UBB_ASYNC;
            MODE_CMD_SYNC:  mode <= UBB_SYNC;
            MODE_CMD_RESET: mode <= UBB_OFF;
            default:        mode <= mode;
         endcase
      end
   end

   // Pin direction, held until the next mode command
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         pinDir <= PIN_RESET_VAL;
      else if (modeCmdValid)
      begin
         if (modeCmd.value == MODE_CMD_ASYNC || modeCmd.value == MODE_CMD_SYNC)
            pinDir <= modeCmd.mask;
         else if (modeCmd.value == MODE_CMD_RESET)
            pinDir <= PIN_RESET_VAL;
      end
   end

   // Transfer engine for both bit-bang modes
   always_ff @(posedge sys_clk)
   begin
      if (srst || modeCmdValid)
      begin
         state           <= ST_IDLE;
         pending         <= 1'b0;
         setupCnt        <= 4'h0;
         fromHostReady   <= 1'b0;
         toHostValid     <= 1'b0;
         pinReadStrobeN  <= 1'b1;
         pinWriteStrobeN <= 1'b1;
         if (srst)
         begin
            holdByte       <= PIN_RESET_VAL;
            toHostData     <= PIN_RESET_VAL;
            pinLevel       <= PIN_RESET_VAL;
         end
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               pinWriteStrobeN <= 1'b1;
               if (mode == UBB_ASYNC)
               begin
                  if (accept)
                  begin
                     holdByte <= fromHostData;
                     pending  <= 1'b1;
                  end
                  else if (pending && baudTick)
                  begin
                     pinLevel        <= holdByte;
                     pinWriteStrobeN <= 1'b0;
                     pending         <= 1'b0;
                  end
                  fromHostReady <= pending ? baudTick : !accept;
                  if (baudTick && toHostFree)
                  begin
                     toHostData     <= pinSync;
                     toHostValid    <= 1'b1;
                     pinReadStrobeN <= 1'b0;
                  end
                  else
                  begin
                     pinReadStrobeN <= 1'b1;
                     if (toHostReady)
                        toHostValid <= 1'b0;
                  end
               end
               else if (mode == UBB_SYNC)
               begin
                  pinReadStrobeN <= 1'b1;
                  if (accept)
                  begin
                     holdByte       <= fromHostData;
                     fromHostReady  <= 1'b0;
                     pinReadStrobeN <= 1'b0;
                     state          <= ST_SAMPLE;
                  end
                  else
                     fromHostReady <= toHostReady && !toHostValid;
               end
               else
               begin
                  fromHostReady  <= 1'b0;
                  toHostValid    <= 1'b0;
                  pinReadStrobeN <= 1'b1;
               end
            end
            ST_SAMPLE:
            begin
               toHostData     <= pinSync;
               toHostValid    <= 1'b1;
               pinReadStrobeN <= 1'b1;
               state          <= ST_SEND;
            end
            ST_SEND:
            begin
               if (toHostReady)
               begin
                  toHostValid    <= 1'b0;
                  pinLevel       <= holdByte;
                  setupCnt       <= 4'h0;
                  state          <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               if (setupCnt == SETUP_CLOCKS - 4'h1)
               begin
                  pinWriteStrobeN <= 1'b0;
                  state           <= ST_STROBE;
               end
               else
                  setupCnt <= setupCnt + 4'h1;
            end
            ST_STROBE:
            begin
               pinWriteStrobeN <= 1'b1;
               state           <= ST_IDLE;
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_write_pulse;
      pinWriteStrobeN ##1 !pinWriteStrobeN ##1 pinWriteStrobeN;
   endsequence

   sequence s_sample_then_send;
      !pinReadStrobeN ##1 (pinReadStrobeN && toHostValid);
   endsequence

   AST_WSTB_ONE_CLOCK: assert property (
      $fell(pinWriteStrobeN) |=> pinWriteStrobeN)
      else $error("write strobe low for more than one clock");

   AST_ASYNC_TICK_PACED: assert property (
      (mode == UBB_ASYNC && $past(mode) == UBB_ASYNC && $changed(pinDrive.level))
      |-> $past(baudTick) && !pinWriteStrobeN)
      else $error("async output changed without a baud tick");

   AST_ASYNC_HOLD: assert property (
      (mode == UBB_ASYNC && !$past(pending) && !$past(modeCmdValid))
      |-> $stable(pinDrive.level))
      else $error("async output changed with no new byte");

   AST_SYNC_SAMPLE_QUEUED: assert property (
      (mode == UBB_SYNC && $fell(pinReadStrobeN) && !modeCmdValid)
      |-> s_sample_then_send)
      else $error("read strobe rise not tied to queued sample");

   AST_SYNC_SETUP_THEN_WSTB: assert property (
      (mode == UBB_SYNC && $changed(pinDrive.level)
       && !$past(modeCmdValid) && !modeCmdValid)
      |-> s_write_pulse)
      else $error("sync write strobe not one clock after update");

   AST_SYNC_SAMPLE_BEFORE_OUT: assert property (
      (mode == UBB_SYNC && $rose(toHostValid))
      |-> toHostData == $past(pinSync) && $stable(pinDrive.level))
      else $error("sync sample not taken before output update");

   AST_SYNC_UPDATE_PER_BYTE: assert property (
      (mode == UBB_SYNC && $changed(pinDrive.level))
      |-> $past(state == ST_SEND) && $past(toHostReady))
      else $error("sync output changed without a received byte");

   AST_SYNC_READ_AFTER_WRITE: assert property (
      (mode == UBB_SYNC && $rose(toHostValid)) |-> $past(state == ST_SAMPLE))
      else $error("sync sample sent without a written byte");

   AST_SYNC_ROOM: assert property (
      (mode == UBB_SYNC && state == ST_IDLE && accept)
      |-> $past(toHostReady) && !toHostValid)
      else $error("sync byte taken with no room toward host");

   AST_MODE_SYNC_ENTRY: assert property (
      (modeCmdValid && modeCmd.value == MODE_CMD_SYNC)
      |=> mode == UBB_SYNC && pinDrive.drive == $past(modeCmd.mask))
      else $error("sync mode or mask not taken");

   AST_MODE_ASYNC_ENTRY: assert property (
      (modeCmdValid && modeCmd.value == MODE_CMD_ASYNC)
      |=> mode == UBB_ASYNC && pinDrive.drive == $past(modeCmd.mask))
      else $error("async mode or mask not taken");

   AST_MODE_RESET: assert property (
      (modeCmdValid && modeCmd.value == MODE_CMD_RESET)
      |=> mode == UBB_OFF && pinDrive.drive == PIN_RESET_VAL && !toHostValid)
      else $error("reset command did not leave bit-bang mode");

   AST_MASK_HELD: assert property (
      !$past(modeCmdValid) |-> $stable(pinDrive.drive))
      else $error("pin direction changed without a mode command");
endmodule // ubb_port
`default_nettype wire

/* tb/ubb_pin_model.sv */
// External logic on the bit-bang pins, latching the bus on write strobes.
// Assumes ubb_pkg is compiled first; undriven pins show extLevel.
`timescale 1ns/1ps
`default_nettype none
module ubb_pin_model
   import ubb_pkg::*;
(
   input  wire ubb_pins_s        pinDrive,
   input  wire logic [PIN_W-1:0] extLevel,
   input  wire logic             pinWriteStrobeN,
   output var  logic [PIN_W-1:0] pinIn,
   output var  logic [PIN_W-1:0] latched
);
   always_comb
   begin
      pinIn = (pinDrive.level & pinDrive.drive)
            | (extLevel & ~pinDrive.drive);
   end

   // Clocked by the strobe rise, as outside logic would be
   always_ff @(posedge pinWriteStrobeN)
   begin
      latched <= pinIn;
   end
endmodule // ubb_pin_model
`default_nettype wire

/* tb/test_usb_parallel_bitbang_port.sv */
// Self-checking bench for the bit-bang port with a pin-side model.
// Assumes ubb_pkg, ubb_sync, ubb_port and ubb_pin_model compiled first.
`timescale 1ns/1ps
`default_nettype none
`define UBB_CHK(nm, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         failCount++; \
         $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
      end \
   end
module test_usb_parallel_bitbang_port;
   import ubb_pkg::*;
   logic             sys_clk       = 1'b0;
   logic             srst          = 1'b1;
   logic             modeCmdValid  = 1'b0;
   ubb_cmd_s         modeCmd       = '0;
   logic             baudTick      = 1'b0;
   logic             fromHostValid = 1'b0;
   logic [PIN_W-1:0] fromHostData  = '0;
   logic             toHostReady   = 1'b1;
   logic [PIN_W-1:0] extLevel      = 8'hA0;
   logic             fromHostReady;
   logic             toHostValid;
   logic [PIN_W-1:0] toHostData;
   logic [PIN_W-1:0] pinIn;
   logic [PIN_W-1:0] latched;
   ubb_pins_s        pinDrive;
   logic             rdN;
   logic             wrN;
   ubb_mode_e        mode;
   int               failCount     = 0;
   int               comparisons   = 0;

   always #2.5 sys_clk = ~sys_clk;

   ubb_port ubb_port_inst (.sys_clk(sys_clk), .srst(srst),
      .modeCmdValid(modeCmdValid), .modeCmd(modeCmd), .baudTick(baudTick),
      .fromHostValid(fromHostValid), .fromHostData(fromHostData),
      .fromHostReady(fromHostReady), .toHostValid(toHostValid),
      .toHostData(toHostData), .toHostReady(toHostReady), .pinIn(pinIn),
      .pinDrive(pinDrive), .pinReadStrobeN(rdN), .pinWriteStrobeN(wrN),
      .mode(mode));
   ubb_pin_model ubb_pin_model_inst (.pinDrive(pinDrive),
      .extLevel(extLevel), .pinWriteStrobeN(wrN), .pinIn(pinIn),
      .latched(latched));

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic setMode(input logic [7:0] v, input logic [7:0] m);
      @(posedge sys_clk);
      modeCmdValid <= 1'b1;
      modeCmd      <= {v, m};
      @(posedge sys_clk);
      modeCmdValid <= 1'b0;
      #1;
   endtask

   task automatic sendByte(input logic [7:0] b);
      int n;
      n = 0;
      @(posedge sys_clk);
      fromHostValid <= 1'b1;
      fromHostData  <= b;
      #1;
      while (fromHostReady !== 1'b1 && n < 50)
      begin
         cyc(1);
         n++;
      end
      `UBB_CHK("accept", 1'b1, fromHostReady)
      @(posedge sys_clk);
      fromHostValid <= 1'b0;
      #1;
   endtask

   task automatic syncCycle(input logic [7:0] b, input logic [7:0] smp,
                            input logic [7:0] pins);
      sendByte(b);
      `UBB_CHK("rdN low", 1'b0, rdN)
      cyc(1);
      `UBB_CHK("rdN rise", 1'b1, rdN)
      `UBB_CHK("toHostValid", 1'b1, toHostValid)
      `UBB_CHK("sample", smp, toHostData)
      cyc(1);
      `UBB_CHK("level", b, pinDrive.level)
      `UBB_CHK("wrN setup", 1'b1, wrN)
      cyc(1);
      `UBB_CHK("wrN low", 1'b0, wrN)
      cyc(1);
      `UBB_CHK("wrN high", 1'b1, wrN)
      `UBB_CHK("pins", pins, latched)
   endtask

   task automatic testReset;
      `UBB_CHK("mode", UBB_OFF, mode)
      `UBB_CHK("drive", 8'h00, pinDrive.drive)
      `UBB_CHK("strobes", 2'b11, {rdN, wrN})
      `UBB_CHK("ready", 1'b0, fromHostReady)
   endtask

   task automatic testSync;
      setMode(MODE_CMD_SYNC, 8'h0F);
      `UBB_CHK("mode sync", UBB_SYNC, mode)
      `UBB_CHK("mask", 8'h0F, pinDrive.drive)
      cyc(3);
      syncCycle(8'h55, 8'hA0, 8'hA5);
      syncCycle(8'hAA, 8'hA5, 8'hAA);
   endtask

   task automatic testStall;
      @(posedge sys_clk);
      toHostReady <= 1'b0;
      repeat (2) @(posedge sys_clk);
      fromHostValid <= 1'b1;
      fromHostData  <= 8'h11;
      repeat (6)
      begin
         cyc(1);
         `UBB_CHK("stall", 1'b0, fromHostReady)
      end
      `UBB_CHK("hold", 8'hAA, pinDrive.level)
      @(posedge sys_clk);
      fromHostValid <= 1'b0;
      toHostReady   <= 1'b1;
      #1;
   endtask

   task automatic testInputs;
      @(posedge sys_clk);
      extLevel <= 8'h3C;
      setMode(MODE_CMD_SYNC, 8'h00);
      cyc(3);
      syncCycle(8'hFF, 8'h3C, 8'h3C);
   endtask

   task automatic tickPulse;
      @(posedge sys_clk);
      baudTick <= 1'b1;
      @(posedge sys_clk);
      baudTick <= 1'b0;
      #1;
   endtask

   task automatic testAsync;
      setMode(MODE_CMD_ASYNC, 8'hFF);
      `UBB_CHK("mode async", UBB_ASYNC, mode)
      cyc(3);
      sendByte(8'h5A);
      cyc(3);
      `UBB_CHK("no tick", 8'hFF, pinDrive.level)
      tickPulse();
      `UBB_CHK("tick level", 8'h5A, pinDrive.level)
      `UBB_CHK("async wrN", 1'b0, wrN)
      `UBB_CHK("async rdN", 1'b0, rdN)
      `UBB_CHK("async smp", 8'hFF, toHostData)
      cyc(1);
      `UBB_CHK("wrN one", 1'b1, wrN)
      tickPulse();
      cyc(1);
      `UBB_CHK("held", 8'h5A, pinDrive.level)
      `UBB_CHK("ext latch", 8'h5A, latched)
      setMode(8'h02, 8'h33);
      `UBB_CHK("unknown mode", UBB_ASYNC, mode)
      `UBB_CHK("unknown mask", 8'hFF, pinDrive.drive)
   endtask

   task automatic testOff;
      setMode(MODE_CMD_RESET, 8'hFF);
      `UBB_CHK("mode off", UBB_OFF, mode)
      `UBB_CHK("off drive", 8'h00, pinDrive.drive)
      @(posedge sys_clk);
      fromHostValid <= 1'b1;
      cyc(3);
      `UBB_CHK("off ready", 1'b0, fromHostReady)
      @(posedge sys_clk);
      fromHostValid <= 1'b0;
      #1;
   endtask

   task automatic summarize;
      if (failCount == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      testReset();
      testSync();
      testStall();
      testInputs();
      testAsync();
      testOff();
      summarize();
   end

   initial
   begin
      #20000;
      failCount++;
      summarize();
   end
endmodule // test_usb_parallel_bitbang_port
`default_nettype wire
